// >>> core/cliu_core.sv
// Notes on behaviour
// - Reset clears text, selects 8-bit defaults.
// - Busy stays high through power-up wait.
// - Three host words (command, data, status) chosen by bus address.
// - While busy, only status read and nibble pairing act.
// - Pointer steps one tick after busy clears.
// - Ordinary instructions take forty microseconds.
// - Clear fills spaces, homes, forces increment.
// - Home zeroes pointer and display shift.
// - Entry mode sets pointer step direction.
// - Shift mode moves display on text writes.
// - Text reads never shift the display.
// - Display off keeps text memory intact.
// - Cursor row is eighth or eleventh line.
// - Blink toggles every 409.6 ms.
// - Shift instruction moves cursor or display.
// - Function set picks width, lines, font.
// - Glyph address selects glyph memory.
// - Text address selects text memory.
// - Status read returns busy and pointer.
// - Data write stores at the pointer.
// - Data read returns byte at pointer.
// - Narrow bus pairs nibbles, high first.
//
// Local design decisions: register access over APB and the placing of the registers.
module cliu_core #(
    parameter int OSC_DIV     = cliu_pkg::OSC_DIV_DEF,
    parameter int BLINK_TICKS = cliu_pkg::BLINK_TICKS_DEF
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);

    // Registered state and its next value.
    cliu_pkg::cliu_regs_type q_q;
    cliu_pkg::cliu_regs_type q_d;

    // Text and glyph memories; no reset, clear fills the text side.
    logic [7:0] text_mem [128];
    logic [7:0] glyph_mem [64];

    // Memory write ports driven from the next-state logic.
    logic       t_we;
    logic [6:0] t_addr;
    logic [7:0] t_wd;
    logic       g_we;
    logic [5:0] g_addr;
    logic [7:0] g_wd;

    // Decoded bus view of the current cycle.
    logic       acc;
    logic       setup;
    logic       hit_cmd;
    logic       hit_data;
    logic       hit_stat;
    logic       busy;
    logic       full;
    logic       go;
    logic       tick;
    logic [7:0] wbyte;
    logic [6:0] eff_addr;
    logic [7:0] mem_byte;
    logic [7:0] src_byte;
    cliu_pkg::cliu_status_type status;

    // Pointer step; glyph addresses wrap in six bits.
    function automatic logic [6:0] step_addr(
        input logic [6:0] a,
        input logic       up,
        input logic       g
    );
        logic [6:0] n;
        n = up ? a + 7'h01 : a - 7'h01;
        return g ? {1'b0, n[5:0]} : n;
    endfunction

    // Display offset step within one line of forty positions.
    function automatic logic [5:0] step_ofs(
        input logic [5:0] o,
        input logic       left
    );
        logic [5:0] n;
        if (left)
        begin
            n = (o == cliu_pkg::LINE_LAST) ? 6'h00 : o + 6'h01;
        end
        else
        begin
            n = (o == 6'h00) ? cliu_pkg::LINE_LAST : o - 6'h01;
        end
        return n;
    endfunction

    // Address decode: command word, data word, status word.
    assign acc      = psel & penable;
    assign setup    = psel & ~penable;
    assign hit_cmd  = paddr == cliu_pkg::OFS_CMD;
    assign hit_data = paddr == cliu_pkg::OFS_DATA;
    assign hit_stat = paddr == cliu_pkg::OFS_STAT;
    assign busy     = q_q.phase != cliu_pkg::PH_IDLE;

    // A narrow bus completes a byte on its second nibble.
    assign full  = q_q.wide | q_q.nib2;
    assign wbyte = q_q.wide ? pwdata[7:0] : {q_q.nib_save, pwdata[7:4]};
    // Accepted only when idle; a busy access only advances the nibble phase.
    assign go    = acc & full & ~busy;

    // A pending step is applied first if a new access overtakes it.
    assign eff_addr = q_q.add_on ?
        step_addr(q_q.addr, q_q.inc, q_q.glyph_sel) : q_q.addr;
    assign mem_byte = q_q.glyph_sel ?
        glyph_mem[eff_addr[5:0]] : text_mem[eff_addr];
    // Busy and pointer need no execution time to read.
    assign src_byte = hit_cmd ? {busy, q_q.addr} : mem_byte;
    assign tick     = q_q.osc_cnt == 8'(OSC_DIV - 1);

    // Zero wait states; unmapped offsets answer with an error.
    assign pready  = 1'b1;
    assign pslverr = acc & ~(hit_cmd | hit_data | hit_stat);
    assign prdata  = q_q.prdata;

    // Status word gathering the live configuration.
    always_comb
    begin
        status             = '0;
        status.busy        = busy;
        status.nib2        = q_q.nib2;
        status.ofs         = q_q.ofs;
        status.cursor_row  = q_q.tall ? cliu_pkg::ROW_TALL
                                      : cliu_pkg::ROW_SHORT;
        status.blink_blank = q_q.blink_on & q_q.blink_ph;
        status.glyph_sel   = q_q.glyph_sel;
        status.shift_en    = q_q.shift_en;
        status.inc         = q_q.inc;
        status.tall        = q_q.tall;
        status.two_line    = q_q.two_line;
        status.wide        = q_q.wide;
        status.blink_on    = q_q.blink_on;
        status.cur_on      = q_q.cur_on;
        status.disp_on     = q_q.disp_on;
    end

    // Next-state logic for the whole unit.
    always_comb
    begin
        q_d    = q_q;
        t_we   = 1'b0;
        t_addr = q_q.fill_idx;
        t_wd   = cliu_pkg::SPACE_CODE;
        g_we   = 1'b0;
        g_addr = eff_addr[5:0];
        g_wd   = wbyte;

        // Oscillator divider; busy, pointer-step and blink times count its ticks.
        q_d.osc_cnt = tick ? 8'h00 : q_q.osc_cnt + 8'h01;

        // Blink phase free-runs so a cursor blinks at once when enabled.
        if (tick)
        begin
            if (q_q.blink_cnt == 17'(BLINK_TICKS - 1))
            begin
                q_d.blink_cnt = 17'h00000;
                q_d.blink_ph  = ~q_q.blink_ph;
            end
            else
            begin
                q_d.blink_cnt = q_q.blink_cnt + 17'h00001;
            end
        end

        // Read data is captured in the setup phase for the access edge.
        if (setup && !pwrite)
        begin
            if (hit_stat)
            begin
                q_d.prdata = 32'(status);
            end
            else if (hit_cmd || hit_data)
            begin
                // Narrow reads show the nibble on the upper lines.
                if (q_q.wide)
                begin
                    q_d.prdata = {24'h000000, src_byte};
                end
                else if (q_q.nib2)
                begin
                    q_d.prdata = {24'h000000, src_byte[3:0], 4'h0};
                end
                else
                begin
                    q_d.prdata = {24'h000000, src_byte[7:4], 4'h0};
                end
            end
            else
            begin
                q_d.prdata = 32'h00000000;
            end
        end

        // Nibble phase advances on every narrow-bus command or data access, busy or not, to stay aligned.
        if (acc && (hit_cmd || hit_data) && !q_q.wide)
        begin
            q_d.nib2 = ~q_q.nib2;
            if (!q_q.nib2)
            begin
                q_d.nib_save = pwdata[7:4];
            end
        end

        // Busy countdown in oscillator ticks.
        if (tick && q_q.busy_cnt != 12'h000)
        begin
            q_d.busy_cnt = q_q.busy_cnt - 12'h001;
        end

        // Busy ends once the count and any fill are done.
        if (busy && q_q.busy_cnt == 12'h000 && !q_q.fill_on)
        begin
            q_d.phase = cliu_pkg::PH_IDLE;
            if (q_q.step_pend)
            begin
                q_d.step_pend = 1'b0;
                q_d.add_on    = 1'b1;
                q_d.add_cnt   = cliu_pkg::ADD_TICKS;
            end
        end

        // Delayed pointer update after the busy indicator has cleared.
        if (q_q.add_on)
        begin
            if (q_q.add_cnt == 12'h000)
            begin
                q_d.add_on = 1'b0;
                q_d.addr   = eff_addr;
            end
            else if (tick)
            begin
                q_d.add_cnt = q_q.add_cnt - 12'h001;
            end
        end

        // Space fill of the text memory, one entry per bus clock.
        if (q_q.fill_on)
        begin
            t_we         = 1'b1;
            q_d.fill_idx = q_q.fill_idx + 7'h01;
            if (q_q.fill_idx == cliu_pkg::TEXT_LAST)
            begin
                q_d.fill_on = 1'b0;
            end
        end

        // Any accepted instruction absorbs an overtaken pointer step.
        if (go && (hit_data || (hit_cmd && pwrite)))
        begin
            q_d.add_on   = 1'b0;
            q_d.addr     = eff_addr;
            q_d.phase    = cliu_pkg::PH_BUSY;
            q_d.busy_cnt = cliu_pkg::CMD_TICKS;
        end

        // Instruction decode by the highest set bit; low bits ignored.
        if (go && hit_cmd && pwrite)
        begin
            if (wbyte[7])
            begin
                q_d.addr      = wbyte[6:0];
                q_d.glyph_sel = 1'b0;
            end
            else if (wbyte[6])
            begin
                q_d.addr      = {1'b0, wbyte[5:0]};
                q_d.glyph_sel = 1'b1;
            end
            else if (wbyte[5])
            begin
                q_d.wide     = wbyte[4];
                q_d.two_line = wbyte[3];
                q_d.tall     = wbyte[2];
            end
            else if (wbyte[4])
            begin
                // Display shift leaves the pointer alone.
                if (wbyte[3])
                begin
                    q_d.ofs = step_ofs(q_q.ofs, ~wbyte[2]);
                end
                else
                begin
                    q_d.addr = step_addr(eff_addr, wbyte[2],
                                         q_q.glyph_sel);
                end
            end
            else if (wbyte[3])
            begin
                // Blanking touches no memory, so contents return at once.
                q_d.disp_on  = wbyte[2];
                q_d.cur_on   = wbyte[1];
                q_d.blink_on = wbyte[0];
            end
            else if (wbyte[2])
            begin
                q_d.inc      = wbyte[1];
                q_d.shift_en = wbyte[0];
            end
            else if (wbyte[1])
            begin
                q_d.addr      = 7'h00;
                q_d.ofs       = 6'h00;
                q_d.glyph_sel = 1'b0;
                q_d.busy_cnt  = cliu_pkg::LONG_TICKS;
            end
            else if (wbyte[0])
            begin
                q_d.addr      = 7'h00;
                q_d.ofs       = 6'h00;
                q_d.inc       = 1'b1;
                q_d.glyph_sel = 1'b0;
                q_d.fill_on   = 1'b1;
                q_d.fill_idx  = 7'h00;
                q_d.busy_cnt  = cliu_pkg::LONG_TICKS;
            end
            else
            begin
                // An all-zero code is no instruction and takes no time.
                q_d.phase    = cliu_pkg::PH_IDLE;
                q_d.busy_cnt = 12'h000;
            end
        end

        // Data access to the selected memory; pointer steps afterwards.
        if (go && hit_data)
        begin
            q_d.step_pend = 1'b1;
            // Only writes may shift; reads leave the offset alone.
            if (pwrite)
            begin
                t_addr = eff_addr;
                t_wd   = wbyte;
                t_we   = ~q_q.glyph_sel;
                g_we   = q_q.glyph_sel;
                if (q_q.shift_en && !q_q.glyph_sel)
                begin
                    q_d.ofs = step_ofs(q_q.ofs, q_q.inc);
                end
            end
        end
    end

    // State register; reset values give the power-up configuration.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q_q          <= '0;
            q_q.phase    <= cliu_pkg::PH_POWERUP;
            q_q.busy_cnt <= cliu_pkg::POR_TICKS;
            q_q.fill_on  <= 1'b1;
            q_q.wide     <= cliu_pkg::RST_WIDE;
            q_q.two_line <= cliu_pkg::RST_TWO;
            q_q.tall     <= cliu_pkg::RST_TALL;
            q_q.disp_on  <= cliu_pkg::RST_DISP;
            q_q.cur_on   <= cliu_pkg::RST_CUR;
            q_q.blink_on <= cliu_pkg::RST_BLINK;
            q_q.inc      <= cliu_pkg::RST_INC;
            q_q.shift_en <= cliu_pkg::RST_SHIFT;
        end
        else
        begin
            q_q <= q_d;
        end
    end

    // Memory write ports; no reset so the arrays map onto RAM.
    always_ff @(posedge pclk)
    begin
        if (t_we)
        begin
            text_mem[t_addr] <= t_wd;
        end
        if (g_we)
        begin
            glyph_mem[g_addr] <= g_wd;
        end
    end

    // Checks on the unit's own behaviour.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_busy_after_cmd: assert property (go && pwrite && hit_cmd &&
        wbyte != 8'h00 |=> busy ##1 busy)
        else $error("accepted instruction did not raise busy");

    a_ignore_busy: assert property (acc && full && busy &&
        pwrite && hit_cmd |=> $stable(q_q.wide) && $stable(q_q.disp_on)
        && $stable(q_q.inc) && $stable(q_q.ofs))
        else $error("instruction acted while busy");

    a_status_read: assert property (setup && !pwrite && hit_cmd &&
        q_q.wide |=> prdata[7:0] == $past({busy, q_q.addr}))
        else $error("status read does not show busy and pointer");

    a_clear_run: assert property (go && pwrite && hit_cmd &&
        wbyte == 8'h01 |=> (q_q.fill_on && q_q.addr == 7'h00 && q_q.inc)
        ##128 (!q_q.fill_on && busy))
        else $error("clear did not fill for 128 cycles");

    a_fill_space: assert property (q_q.fill_on |->
        t_we && t_wd == cliu_pkg::SPACE_CODE && !g_we)
        else $error("fill wrote something other than a space");

    a_read_noshift: assert property (go && hit_data &&
        !pwrite |=> $stable(q_q.ofs))
        else $error("text read shifted the display");

    a_shift_write: assert property (go && hit_data && pwrite &&
        q_q.shift_en && !q_q.glyph_sel && q_q.inc &&
        q_q.ofs != cliu_pkg::LINE_LAST |=> q_q.ofs == $past(q_q.ofs) + 6'h01)
        else $error("shifted write did not move display left");

    a_nibble_pair: assert property (acc && (hit_cmd || hit_data) &&
        !q_q.wide && !q_q.nib2 |=> q_q.nib2 &&
        q_q.nib_save == $past(pwdata[7:4]))
        else $error("first nibble not held for pairing");

    a_pointer_wait: assert property (busy && q_q.busy_cnt == 12'h000 &&
        !q_q.fill_on && q_q.step_pend |=> !busy && q_q.add_on &&
        $stable(q_q.addr))
        else $error("pointer stepped before busy cleared");

    a_func_set: assert property (go && pwrite && hit_cmd &&
        wbyte[7:5] == 3'b001 |=> q_q.wide == $past(wbyte[4]) &&
        q_q.tall == $past(wbyte[2]))
        else $error("function set not applied");

    a_glyph_sel: assert property (go && pwrite && hit_cmd &&
        wbyte[7:6] == 2'b01 |=> q_q.glyph_sel &&
        q_q.addr == {1'b0, $past(wbyte[5:0])})
        else $error("glyph address not loaded");

    c_clear: cover property (go && pwrite && hit_cmd && wbyte == 8'h01);
    c_narrow_write: cover property (go && pwrite && hit_data && !q_q.wide);
    c_shift_write: cover property (go && pwrite && hit_data && q_q.shift_en);
    c_ptr_update: cover property (q_q.add_on && q_q.add_cnt == 12'h000);

endmodule

// >>> shared/cliu_pkg.sv
package cliu_pkg;

    // Byte offsets of the three words in the APB window.
    localparam logic [11:0] OFS_CMD  = 12'h000;
    localparam logic [11:0] OFS_DATA = 12'h004;
    localparam logic [11:0] OFS_STAT = 12'h008;

    // Bus clock and nominal internal oscillator rate.
    localparam int CLK_HZ      = 25000000;
    localparam int OSC_HZ      = 250000;
    localparam int OSC_DIV_DEF = CLK_HZ / OSC_HZ;
    localparam int OSC_NS      = 1000000000 / OSC_HZ;

    // Execution and display times in nanoseconds.
    localparam int T_CMD_NS   = 40000;
    localparam int T_LONG_NS  = 1640000;
    localparam int T_POR_NS   = 10000000;
    localparam int T_ADD_NS   = 6000;
    localparam int T_BLINK_NS = 409600000;

    // Times as oscillator ticks; maxima round down, the power-up wait up.
    localparam logic [11:0] CMD_TICKS  = 12'(T_CMD_NS / OSC_NS);
    localparam logic [11:0] LONG_TICKS = 12'(T_LONG_NS / OSC_NS);
    localparam logic [11:0] POR_TICKS  = 12'((T_POR_NS + OSC_NS - 1) / OSC_NS);
    localparam logic [11:0] ADD_TICKS  = 12'(T_ADD_NS / OSC_NS);
    localparam int          BLINK_TICKS_DEF = T_BLINK_NS / OSC_NS;

    // Memory contents and geometry.
    localparam logic [7:0] SPACE_CODE = 8'h20;
    localparam logic [6:0] TEXT_LAST  = 7'h7f;
    localparam logic [5:0] LINE_LAST  = 6'h27;
    localparam logic [3:0] ROW_SHORT  = 4'h7;
    localparam logic [3:0] ROW_TALL   = 4'ha;

    // Reset values of the configuration bits.
    localparam logic RST_WIDE  = 1'b1;
    localparam logic RST_TWO   = 1'b0;
    localparam logic RST_TALL  = 1'b0;
    localparam logic RST_DISP  = 1'b0;
    localparam logic RST_CUR   = 1'b0;
    localparam logic RST_BLINK = 1'b0;
    localparam logic RST_INC   = 1'b1;
    localparam logic RST_SHIFT = 1'b0;

    // Execution phase of the unit.
    typedef enum logic [1:0] {PH_POWERUP, PH_IDLE, PH_BUSY} cliu_phase_type;

    // Layout of the status word, most significant field first.
    typedef struct packed {
        logic [7:0] zero;
        logic       busy;
        logic       nib2;
        logic [5:0] ofs;
        logic [3:0] cursor_row;
        logic [1:0] pad;
        logic       blink_blank;
        logic       glyph_sel;
        logic       shift_en;
        logic       inc;
        logic       tall;
        logic       two_line;
        logic       wide;
        logic       blink_on;
        logic       cur_on;
        logic       disp_on;
    } cliu_status_type;

    // Complete state of the unit.
    typedef struct packed {
        cliu_phase_type phase;
        logic [7:0]     osc_cnt;
        logic [11:0]    busy_cnt;
        logic           fill_on;
        logic [6:0]     fill_idx;
        logic [6:0]     addr;
        logic           glyph_sel;
        logic           inc;
        logic           shift_en;
        logic           disp_on;
        logic           cur_on;
        logic           blink_on;
        logic           wide;
        logic           two_line;
        logic           tall;
        logic [5:0]     ofs;
        logic           step_pend;
        logic           add_on;
        logic [11:0]    add_cnt;
        logic           nib2;
        logic [3:0]     nib_save;
        logic [16:0]    blink_cnt;
        logic           blink_ph;
        logic [31:0]    prdata;
    } cliu_regs_type;

endpackage

// >>> sim/cliu_host.sv
// Host processor side of the bus: one transfer at a time, polling busy.
module cliu_host (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    // Error response seen on the most recent transfer.
    logic err;

    // The bus rests idle until the first request.
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
        err     = 1'b0;
    end

    // Setup then access; the request holds until pready is seen high.
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q       = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Polls busy, then lets the delayed pointer step land.
    task automatic idle();
        logic [31:0] s;
        s = 32'hffff_ffff;
        for (int i = 0; i < 6000 && s[23] !== 1'b0; i++)
            xfer(1'b0, cliu_pkg::OFS_STAT, 32'h0, s);
        repeat (12) @(posedge pclk);
    endtask

    // Write only once the unit is idle, so nothing is dropped.
    task automatic put(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        idle();
        xfer(1'b1, a, d, q);
    endtask

    // Read only once the unit is idle.
    task automatic get(input logic [11:0] a, output logic [31:0] q);
        idle();
        xfer(1'b0, a, 32'h0, q);
    endtask
endmodule

// >>> sim/cliu_core_test.sv
// Drives the unit from a host model and checks each instruction.
module cliu_core_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] oc = cliu_pkg::OFS_CMD;
    localparam logic [11:0] od = cliu_pkg::OFS_DATA;
    localparam logic [11:0] os = cliu_pkg::OFS_STAT;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int          miscompares = 0;
    int          comparisons = 0;

    // A short oscillator divider keeps the power-up wait brief.
    cliu_core #(.OSC_DIV(4), .BLINK_TICKS(8)) u_cliu_core (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    cliu_host u_cliu_host (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    // Bus clock at 25 MHz.
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic finish_test();
        if (miscompares == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    // Pointer from the command byte, and display offset from status.
    task automatic ptr(input logic [6:0] e);
        u_cliu_host.get(oc, q);
        chk({25'h0, q[6:0]}, {25'h0, e});
    endtask
    task automatic ofs(input logic [5:0] e);
        u_cliu_host.get(os, q);
        chk({26'h0, q[21:16]}, {26'h0, e});
    endtask

    // Busy through power-up, then the documented defaults.
    task automatic t_power();
        u_cliu_host.xfer(1'b0, oc, 32'h0, q);
        chk({31'h0, q[7]}, 32'h1);
        u_cliu_host.get(os, q);
        chk({19'h0, q[15:12], q[8:0]}, 32'h0e48);
        u_cliu_host.get(od, q);
        chk(q, 32'h20);
    endtask

    // Text write steps the pointer; the byte reads back.
    task automatic t_text();
        u_cliu_host.put(oc, 32'h85);
        u_cliu_host.put(od, 32'h41);
        ptr(7'h06);
        u_cliu_host.put(oc, 32'h85);
        u_cliu_host.get(od, q);
        chk(q, 32'h41);
    endtask

    // Decrement, shift on write only, then explicit shifts.
    task automatic t_entry();
        u_cliu_host.put(oc, 32'h04);
        u_cliu_host.put(oc, 32'h8a);
        u_cliu_host.put(od, 32'h33);
        ptr(7'h09);
        u_cliu_host.put(oc, 32'h07);
        u_cliu_host.put(od, 32'h34);
        ofs(6'h01);
        u_cliu_host.get(od, q);
        ofs(6'h01);
        u_cliu_host.put(oc, 32'h1c);
        u_cliu_host.put(oc, 32'h14);
        ofs(6'h00);
        ptr(7'h0c);
    endtask

    // Home undoes the shift; clear fills spaces and forces increment.
    task automatic t_clear();
        u_cliu_host.put(oc, 32'h18);
        u_cliu_host.put(oc, 32'h02);
        ofs(6'h00);
        ptr(7'h00);
        u_cliu_host.put(oc, 32'h05);
        u_cliu_host.put(oc, 32'h8f);
        u_cliu_host.put(oc, 32'h01);
        u_cliu_host.get(os, q);
        chk({30'h0, q[7:6]}, 32'h3);
        ptr(7'h00);
        u_cliu_host.put(oc, 32'h85);
        u_cliu_host.get(od, q);
        chk(q, 32'h20);
    endtask

    // A command sent while busy is dropped; don't-care bits ignored.
    task automatic t_busy();
        u_cliu_host.put(oc, 32'h91);
        u_cliu_host.xfer(1'b1, oc, 32'ha0, q);
        u_cliu_host.xfer(1'b0, oc, 32'h0, q);
        chk({31'h0, q[7]}, 32'h1);
        ptr(7'h11);
        u_cliu_host.put(oc, 32'h03);
        ptr(7'h00);
    endtask

    // Display bits, tall font, glyph memory, display off.
    task automatic t_disp();
        logic b;
        u_cliu_host.put(oc, 32'h0f);
        u_cliu_host.put(oc, 32'h3c);
        u_cliu_host.get(os, q);
        chk({19'h0, q[15:12], q[8:0]}, 32'h14ff);
        // Two status samples one blink half-period apart must differ.
        u_cliu_host.xfer(1'b0, os, 32'h0, q);
        b = q[9];
        repeat (29) @(posedge pclk);
        u_cliu_host.xfer(1'b0, os, 32'h0, q);
        chk({31'h0, q[9]}, {31'h0, ~b});
        u_cliu_host.put(oc, 32'h43);
        u_cliu_host.put(od, 32'h1f);
        u_cliu_host.put(oc, 32'h43);
        u_cliu_host.get(od, q);
        chk(q, 32'h1f);
        u_cliu_host.put(oc, 32'h08);
        u_cliu_host.get(os, q);
        chk({23'h0, q[8:0]}, 32'h1f8);
    endtask

    // Narrow bus: high nibble first for commands and data.
    task automatic t_narrow();
        u_cliu_host.put(oc, 32'h20);
        u_cliu_host.put(oc, 32'h80);
        u_cliu_host.put(oc, 32'h70);
        u_cliu_host.put(od, 32'h50);
        u_cliu_host.put(od, 32'ha0);
        u_cliu_host.put(oc, 32'h80);
        u_cliu_host.put(oc, 32'h70);
        u_cliu_host.get(od, q);
        chk(q, 32'h50);
        u_cliu_host.get(od, q);
        chk(q, 32'ha0);
        u_cliu_host.put(oc, 32'h30);
        u_cliu_host.put(oc, 32'h00);
        u_cliu_host.put(oc, 32'h87);
        u_cliu_host.get(od, q);
        chk(q, 32'h5a);
        u_cliu_host.xfer(1'b0, 12'h00c, 32'h0, q);
        chk({q[30:0], u_cliu_host.err}, 32'h1);
    endtask

    // Reset for ten cycles, then every scenario in turn.
    initial
    begin
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_power();
        t_text();
        t_entry();
        t_clear();
        t_busy();
        t_disp();
        t_narrow();
        finish_test();
    end

    // A hang counts as a mismatch and ends the run.
    initial
    begin
        repeat (60000) @(posedge pclk);
        miscompares++;
        finish_test();
    end
endmodule
